// ---- bcu_top.v ----
// Bus cycle breakpoint unit: registers, cycle capture, request logic.
// Assumes bus cycle attributes, ack and next PC come from logic on clk.
//
// Function
// - Control bit 0 set suppresses break requests
// - Initiator, kind or direction field 00 means never break
// - Full condition match sends break request out
// - Paired fetch gives each instruction its own break
// - Fetch break saves matched address, before execution
// - Deferred fetch break saves following instruction address
// - Data break saves address after last executed
// - Fetch with write-only direction never matches
// - Transfer initiators with fetch-only never match
// - Address compare is exact against issued address
// - Odd branch target break follows address error
// - Data break needs address, initiator, direction, size
// - Mask bit one removes address bit from compare
// - Initiator field: 01 CPU, 10 DMA, 11 both
// - Direction and kind fields: 01, 10, 11 decode
// - Size field: 00 any, byte, word, long
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "bcu_consts.vh"

module bcu_top (
  input wire clk,
  input wire rst,
  // APB register port
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  // Monitored bus cycle, one valid pulse per cycle
  input wire bus_valid,
  input wire [31:0] bus_addr,
  input wire bus_dma,
  input wire bus_fetch,
  input wire bus_write,
  input wire [1:0] bus_size,
  input wire bus_dual,
  input wire bus_branch_first,
  // CPU status for the saved counter
  input wire cpu_defer,
  input wire [31:0] cpu_next_pc,
  // Interrupt controller hand-shake
  input wire break_ack,
  output reg break_req_r,
  output reg [31:0] break_pc_r,
  output reg break_on_fetch_r,
  output reg break_after_addr_err_r
);

  // Break address, high and low halves
  reg [15:0] addr_hi_r;
  reg [15:0] addr_lo_r;
  // Break address mask, high and low halves
  reg [15:0] mask_hi_r;
  reg [15:0] mask_lo_r;
  // Bus cycle select: initiator, kind, direction, size fields
  reg [7:0] bus_cycle_select_reg_r;
  // Break request inhibit bit of break control
  reg break_request_inhibit_r;

  // Read data and decode for the APB slave
  reg [31:0] rdata;
  reg addr_hit;
  // Write commit pulse from the slave
  wire wr_commit;

  // Captured bus cycle
  // A cycle was captured at the last edge
  reg cap_valid_r;
  // Issued address
  reg [31:0] cap_addr_r;
  // Initiator is a transfer controller
  reg cap_dma_r;
  // Instruction fetch rather than data access
  reg cap_fetch_r;
  // Write direction
  reg cap_write_r;
  // Operand size code
  reg [1:0] cap_size_r;
  // Fetch carried two instructions
  reg cap_dual_r;
  // First fetch after a branch
  reg cap_branch_r;
  // Fetched instruction cannot take a break at once
  reg cap_defer_r;
  // Counter after the last executed instruction
  reg [31:0] cap_next_pc_r;

  // Second instruction of a paired fetch waiting behind the first
  reg second_pend_r;
  // Saved counter of the waiting latter instruction
  reg [31:0] second_pc_r;
  // Odd-target flag of the waiting latter instruction
  reg second_aerr_r;

  // Start address of the instruction right after the one at a
  function [31:0] insn_after;
    input [31:0] a;
    begin
      insn_after = a + `BCU_INSN_STEP;
    end
  endfunction

  // Compare results
  // Former instruction, or the whole cycle when not a paired fetch
  wire hit_first;
  // Latter instruction of a paired fetch
  wire hit_second;
  // Full break address and mask
  wire [31:0] brk_addr = {addr_hi_r, addr_lo_r};
  wire [31:0] brk_mask = {mask_hi_r, mask_lo_r};
  // Address of the latter instruction of a paired fetch
  wire [31:0] addr_second = insn_after(cap_addr_r);

  // Register address decode and read mux
  always @* begin
    rdata = `BCU_ZERO32;
    addr_hit = 1'b1;
    case (paddr)
      `BCU_OFS_ADDR_HI: begin
        rdata = {`BCU_ZERO16, addr_hi_r};
      end
      `BCU_OFS_ADDR_LO: begin
        rdata = {`BCU_ZERO16, addr_lo_r};
      end
      `BCU_OFS_MASK_HI: begin
        rdata = {`BCU_ZERO16, mask_hi_r};
      end
      `BCU_OFS_MASK_LO: begin
        rdata = {`BCU_ZERO16, mask_lo_r};
      end
      `BCU_OFS_CYC_SEL: begin
        // Reserved high byte reads zero
        rdata = {`BCU_ZERO16, `BCU_ZERO8, bus_cycle_select_reg_r};
      end
      `BCU_OFS_CTRL: begin
        // Bits 15 to 1 read zero
        rdata = {`BCU_ZERO16, `BCU_ZERO15,
                 break_request_inhibit_r};
      end
      default: begin
        // Unmapped offset
        addr_hit = 1'b0;
      end
    endcase
  end

  // APB handshake and registered answer
  bcu_apb u_apb (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .addr_hit(addr_hit),
    .rdata_in(rdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .wr_commit(wr_commit)
  );

  // Register writes at the completing APB edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_hi_r <= `BCU_RST_HALF;
      addr_lo_r <= `BCU_RST_HALF;
      mask_hi_r <= `BCU_RST_HALF;
      mask_lo_r <= `BCU_RST_HALF;
      bus_cycle_select_reg_r <= `BCU_RST_CYC_SEL;
      break_request_inhibit_r <= `BCU_RST_CTRL;
    end else if (wr_commit) begin
      case (paddr)
        `BCU_OFS_ADDR_HI: begin
          addr_hi_r <= pwdata[15:0];
        end
        `BCU_OFS_ADDR_LO: begin
          addr_lo_r <= pwdata[15:0];
        end
        `BCU_OFS_MASK_HI: begin
          mask_hi_r <= pwdata[15:0];
        end
        `BCU_OFS_MASK_LO: begin
          mask_lo_r <= pwdata[15:0];
        end
        `BCU_OFS_CYC_SEL: begin
          // Only the low byte holds fields
          bus_cycle_select_reg_r <= pwdata[7:0];
        end
        `BCU_OFS_CTRL: begin
          // Only the inhibit bit is stored
          break_request_inhibit_r <=
            pwdata[`BCU_CTRL_INHIBIT];
        end
        default: begin
          // Unmapped writes are refused by the slave
          addr_hi_r <= addr_hi_r;
        end
      endcase
    end
  end

  // Capture each bus cycle once, on its valid pulse
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_valid_r <= 1'b0;
      cap_addr_r <= `BCU_ZERO32;
      cap_dma_r <= 1'b0;
      cap_fetch_r <= 1'b0;
      cap_write_r <= 1'b0;
      cap_size_r <= `BCU_SIZE_ANY;
      cap_dual_r <= 1'b0;
      cap_branch_r <= 1'b0;
      cap_defer_r <= 1'b0;
      cap_next_pc_r <= `BCU_ZERO32;
    end else begin
      // One compare per bus cycle
      cap_valid_r <= bus_valid;
      if (bus_valid) begin
        cap_addr_r <= bus_addr;
        cap_dma_r <= bus_dma;
        cap_fetch_r <= bus_fetch;
        cap_write_r <= bus_write;
        cap_size_r <= bus_size;
        cap_dual_r <= bus_dual;
        cap_branch_r <= bus_branch_first;
        cap_defer_r <= cpu_defer;
        cap_next_pc_r <= cpu_next_pc;
      end
    end
  end

  // Compare of the cycle's issued address
  bcu_match u_match_first (
    .addr_reg(brk_addr),
    .mask_reg(brk_mask),
    .cyc_sel(bus_cycle_select_reg_r),
    .cyc_addr(cap_addr_r),
    .cyc_dma(cap_dma_r),
    .cyc_fetch(cap_fetch_r),
    .cyc_write(cap_write_r),
    .cyc_size(cap_size_r),
    .hit(hit_first)
  );

  // Compare of the latter instruction in a paired fetch
  bcu_match u_match_second (
    .addr_reg(brk_addr),
    .mask_reg(brk_mask),
    .cyc_sel(bus_cycle_select_reg_r),
    .cyc_addr(addr_second),
    .cyc_dma(cap_dma_r),
    .cyc_fetch(cap_fetch_r),
    .cyc_write(cap_write_r),
    .cyc_size(cap_size_r),
    .hit(hit_second)
  );

  // A match raises a request only while not inhibited
  wire fire_first = cap_valid_r & hit_first &
                    ~break_request_inhibit_r;
  // Latter instruction gets its own independent break
  wire fire_second = cap_valid_r & cap_dual_r & cap_fetch_r & ~cap_dma_r &
                     hit_second & ~break_request_inhibit_r;
  // Either instruction, or the data cycle, asks for a break
  wire fire = fire_first | fire_second;

  // Fetch break of the first instruction: matched address, or the
  // following one when that instruction cannot take the break at once
  wire [31:0] pc_fetch_first = cap_defer_r ? addr_second :
                               cap_addr_r;
  // Latter instruction breaks after the former has executed
  wire [31:0] pc_fetch_second = cap_defer_r ?
                                insn_after(addr_second) :
                                addr_second;
  // Data breaks are imprecise: next instruction after the last executed
  wire [31:0] pc_data = cap_next_pc_r;
  // A data cycle from a transfer controller never counts as a fetch
  wire is_fetch = cap_fetch_r & ~cap_dma_r;
  // Saved counter for the request raised now
  wire [31:0] pc_now = ~is_fetch ? pc_data :
                       (fire_first ? pc_fetch_first : pc_fetch_second);
  // Odd fetch address happens only at a branch target
  wire odd_target = is_fetch & cap_branch_r &
                    cap_addr_r[0] & fire_first;

  // Request may be (re)loaded when idle or being accepted this cycle
  wire slot_free = ~break_req_r | break_ack;

  // Break request: held until accepted, new match wins over the accept unless a latter instruction is queued
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      break_req_r <= 1'b0;
      break_pc_r <= `BCU_ZERO32;
      break_on_fetch_r <= 1'b0;
      break_after_addr_err_r <= 1'b0;
      second_pend_r <= 1'b0;
      second_pc_r <= `BCU_ZERO32;
      second_aerr_r <= 1'b0;
    end else if (fire & slot_free & ~second_pend_r) begin
      // Fresh request from this bus cycle
      break_req_r <= 1'b1;
      // Counter the CPU saves when it takes this break
      break_pc_r <= pc_now;
      break_on_fetch_r <= is_fetch;
      // Tells the CPU to sequence the break after address error handling
      break_after_addr_err_r <= odd_target;
      // Both instructions matched: queue the latter behind the former
      second_pend_r <= fire_first & fire_second;
      // Latter instruction's counter waits here
      second_pc_r <= pc_fetch_second;
      // The latter never starts at a branch target
      second_aerr_r <= 1'b0;
    end else if (break_req_r & break_ack) begin
      if (second_pend_r) begin
        // Former accepted, now present the latter
        break_req_r <= 1'b1;
        break_pc_r <= second_pc_r;
        break_on_fetch_r <= 1'b1;
        break_after_addr_err_r <= second_aerr_r;
        second_pend_r <= 1'b0;
      end else begin
        // Accepted, request drops
        break_req_r <= 1'b0;
        break_on_fetch_r <= 1'b0;
        break_after_addr_err_r <= 1'b0;
      end
    end else begin
      // Still masked at the controller: keep pending unchanged
      break_req_r <= break_req_r;
    end
  end

endmodule // bcu_top

// ---- bcu_consts.vh ----
// Constants for the bus cycle breakpoint unit: offsets, fields, resets.
// Assumes inclusion by bare name from every design file of the unit.
`ifndef BCU_CONSTS_VH
`define BCU_CONSTS_VH

// Width of the APB address that the unit decodes
`define BCU_PADDR_W 8

// Register byte offsets, one aligned 32-bit word each
`define BCU_OFS_ADDR_HI 8'h00
`define BCU_OFS_ADDR_LO 8'h04
`define BCU_OFS_MASK_HI 8'h08
`define BCU_OFS_MASK_LO 8'h0c
`define BCU_OFS_CYC_SEL 8'h10
`define BCU_OFS_CTRL 8'h14

// Reset values
`define BCU_RST_HALF 16'h0000
`define BCU_RST_CYC_SEL 8'h00
`define BCU_RST_CTRL 1'b0

// Break control: request inhibit bit
`define BCU_CTRL_INHIBIT 0

// Bus cycle select: field low bit positions, each field two bits wide
`define BCU_INIT_LSB 6
`define BCU_KIND_LSB 4
`define BCU_DIR_LSB 2
`define BCU_SIZE_LSB 0

// Operand size codes
`define BCU_SIZE_ANY 2'h0
`define BCU_SIZE_BYTE 2'h1
`define BCU_SIZE_WORD 2'h2
`define BCU_SIZE_LONG 2'h3

// Distance between two instructions of one paired fetch
`define BCU_INSN_STEP 32'h00000002

// Zero word for reads of unmapped or reserved bits
`define BCU_ZERO32 32'h00000000
`define BCU_ZERO16 16'h0000
`define BCU_ZERO8 8'h00
`define BCU_ZERO15 15'h0000

`endif

// ---- bcu_match.v ----
// Combinational break condition compare for one bus cycle address.
// Assumes cycle attributes come from flops on the same clock.
`timescale 1ns/1ps
`include "bcu_consts.vh"

module bcu_match (
  input wire [31:0] addr_reg,
  input wire [31:0] mask_reg,
  input wire [7:0] cyc_sel,
  input wire [31:0] cyc_addr,
  input wire cyc_dma,
  input wire cyc_fetch,
  input wire cyc_write,
  input wire [1:0] cyc_size,
  output wire hit
);

  // Two-bit select: bit 0 picks the first kind, bit 1 the second; 00 none
  function sel_ok;
    input [1:0] f;
    input first;
    input second;
    begin
      sel_ok = (f[0] & first) | (f[1] & second);
    end
  endfunction

  // Transfer controllers never fetch, so their cycles are data accesses
  wire fetch_eff = cyc_fetch & ~cyc_dma;
  // Fetches are always reads
  wire write_eff = cyc_write & ~fetch_eff;
  // Fetches always count as word size
  wire [1:0] size_eff = fetch_eff ? `BCU_SIZE_WORD : cyc_size;
  wire [1:0] sz_sel = cyc_sel[`BCU_SIZE_LSB+1:`BCU_SIZE_LSB];

  // Masked bits drop out, the rest compare exactly
  wire addr_ok = (((cyc_addr ^ addr_reg) & ~mask_reg) ==
                  `BCU_ZERO32);
  // Initiator: CPU first, DMA or transfer controller second
  wire init_ok = sel_ok(cyc_sel[`BCU_INIT_LSB+1:`BCU_INIT_LSB],
                        ~cyc_dma, cyc_dma);
  // Fetch first, data access second
  wire kind_ok = sel_ok(cyc_sel[`BCU_KIND_LSB+1:`BCU_KIND_LSB],
                        fetch_eff, ~fetch_eff);
  // Read first, write second
  wire dir_ok = sel_ok(cyc_sel[`BCU_DIR_LSB+1:`BCU_DIR_LSB],
                       ~write_eff, write_eff);
  // Size code 00 ignores size
  wire size_ok = (sz_sel == `BCU_SIZE_ANY) | (sz_sel == size_eff);

  // Every programmed condition must hold together
  assign hit = addr_ok & init_ok & kind_ok & dir_ok & size_ok;

endmodule // bcu_match

// ---- bcu_apb.v ----
// APB slave handshake: registered answer, one access cycle, no wait.
// Assumes the parent supplies address decode and read data combinationally.
`timescale 1ns/1ps
`include "bcu_consts.vh"

module bcu_apb (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire addr_hit,
  input wire [31:0] rdata_in,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output wire wr_commit
);

  // Setup cycle of a transfer
  wire setup = psel & ~penable;
  // Completing access cycle
  wire done = psel & penable & pready;

  // Answer prepared in setup, presented throughout the single access cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= `BCU_ZERO32;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        // Unmapped addresses answer with an error and zero data
        pslverr <= ~addr_hit;
        prdata <= (pwrite | ~addr_hit) ? `BCU_ZERO32 : rdata_in;
      end else if (done) begin
        // Answer withdrawn after completion
        pslverr <= 1'b0;
        prdata <= `BCU_ZERO32;
      end
    end
  end

  // Write takes effect only at the completing edge
  assign wr_commit = done & pwrite & addr_hit;

endmodule // bcu_apb

// ---- bcu_asserts.sv ----
// Port checker for the breakpoint unit, bound to its top module.
// Assumes one clock, async reset and the register map of the unit.
`timescale 1ns/1ps

module bcu_asserts (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire bus_valid,
  input wire [31:0] bus_addr,
  input wire bus_dma,
  input wire bus_dual,
  input wire cpu_defer,
  input wire [31:0] cpu_next_pc,
  input wire break_ack,
  input wire break_req_r,
  input wire [31:0] break_pc_r,
  input wire break_on_fetch_r
);
  reg [31:0] a_r, m_r; // Shadow address and mask
  reg [7:0] s_r; // Shadow cycle select
  reg i_r, rq1_r; // Shadow inhibit, request one edge back
  reg [1:0] vq_r, aq_r; // Valid and ack history
  wire cm = psel & penable & pready & pwrite; // Committed write
  // Initiator, kind or direction field is 00
  wire zf = ~|s_r[7:6] | ~|s_r[5:4] | ~|s_r[3:2];
  // Request rising from a bus cycle two edges back, no ack nearby
  wire fr = break_req_r & ~rq1_r & vq_r[1] & ~|aq_r;

  // Shadow registers and history
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      a_r <= 32'h0;
      m_r <= 32'h0;
      s_r <= 8'h0;
      i_r <= 1'b0;
      rq1_r <= 1'b0;
      vq_r <= 2'h0;
      aq_r <= 2'h0;
    end else begin
      rq1_r <= break_req_r;
      vq_r <= {vq_r[0], bus_valid};
      aq_r <= {aq_r[0], break_ack};
      if (cm) begin
        case (paddr)
          8'h00: a_r[31:16] <= pwdata[15:0];
          8'h04: a_r[15:0] <= pwdata[15:0];
          8'h08: m_r[31:16] <= pwdata[15:0];
          8'h0c: m_r[15:0] <= pwdata[15:0];
          8'h10: s_r <= pwdata[7:0];
          8'h14: i_r <= pwdata[0];
          default: ;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_hold;
    break_req_r && !break_ack |=> break_req_r;
  endproperty
  a_hold: assert property (p_hold)
    else $error("request dropped before ack");
  property p_src;
    $rose(break_req_r) |-> vq_r[1] || $past(break_ack) || $past(break_ack, 2);
  endproperty
  a_src: assert property (p_src)
    else $error("request without a bus cycle");
  property p_inh;
    fr |-> !($past(i_r) && $past(i_r, 2));
  endproperty
  a_inh: assert property (p_inh)
    else $error("request while inhibited");
  property p_sel;
    fr |-> !($past(zf) && $past(zf, 2));
  endproperty
  a_sel: assert property (p_sel)
    else $error("request with a zero select field");
  property p_fwr;
    fr && break_on_fetch_r |-> $past(s_r[3:2]) != 2'h2;
  endproperty
  a_fwr: assert property (p_fwr)
    else $error("fetch break on write-only select");
  property p_dma;
    fr |-> !($past(bus_dma, 2) && $past(s_r[5:4]) == 2'h1);
  endproperty
  a_dma: assert property (p_dma)
    else $error("transfer cycle matched fetch-only select");
  property p_fpc;
    fr && break_on_fetch_r && !$past(bus_dual, 2) && !$past(cpu_defer, 2)
      |-> break_pc_r == $past(bus_addr, 2);
  endproperty
  a_fpc: assert property (p_fpc)
    else $error("fetch break saved counter wrong");
  property p_dfr;
    fr && break_on_fetch_r && !$past(bus_dual, 2) && $past(cpu_defer, 2)
      |-> break_pc_r == $past(bus_addr, 2) + 32'h2;
  endproperty
  a_dfr: assert property (p_dfr)
    else $error("deferred break saved counter wrong");
  property p_dpc;
    fr && !break_on_fetch_r |-> break_pc_r == $past(cpu_next_pc, 2);
  endproperty
  a_dpc: assert property (p_dpc)
    else $error("data break saved counter wrong");
  property p_adr;
    fr && !$past(bus_dual, 2)
      |-> (($past(bus_addr, 2) ^ $past(a_r)) & ~$past(m_r)) == 32'h0;
  endproperty
  a_adr: assert property (p_adr)
    else $error("request on an address mismatch");

  c_fetch: cover property (fr && break_on_fetch_r);
  c_data: cover property (fr && !break_on_fetch_r);
  c_pend: cover property (break_req_r && !break_ack);
endmodule // bcu_asserts

bind bcu_top bcu_asserts u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .bus_valid(bus_valid), .bus_addr(bus_addr),
  .bus_dma(bus_dma), .bus_dual(bus_dual), .cpu_defer(cpu_defer),
  .cpu_next_pc(cpu_next_pc), .break_ack(break_ack),
  .break_req_r(break_req_r), .break_pc_r(break_pc_r),
  .break_on_fetch_r(break_on_fetch_r));

// ---- bcu_irq_model.sv ----
// Interrupt controller model taking break requests by mask level.
// Assumes the request is a level held until acknowledged.
`timescale 1ns/1ps

module bcu_irq_model (
  input wire clk,
  input wire rst,
  input wire break_req_r,
  input wire [31:0] break_pc_r,
  input wire break_after_addr_err_r,
  input wire [3:0] mask_lvl,
  output wire break_ack,
  output reg [7:0] taken_r,
  output reg [31:0] pc_r,
  output reg ae_r
);
  // Level 15 request, taken only at mask 14 or lower, else pending
  assign break_ack = break_req_r & (mask_lvl <= 4'he);

  // Record each accepted break as the CPU would save it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      taken_r <= 8'h00;
      pc_r <= 32'h0;
      ae_r <= 1'b0;
    end else if (break_ack) begin
      taken_r <= taken_r + 8'h01;
      pc_r <= break_pc_r;
      ae_r <= break_after_addr_err_r;
    end
  end
endmodule // bcu_irq_model

// ---- tb_top.sv ----
// Testbench: APB register checks and bus cycle break scenarios.
// Assumes the unit answers APB in one access cycle.
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  n_checks = n_checks + 1; \
  if ((g) !== (e)) begin \
    $display("FAIL %s exp %h got %h", n, e, g); \
    error_cnt = error_cnt + 1; \
  end \
end

module tb_top;
  reg clk, rst, psel, penable, pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata, bus_addr, cpu_next_pc, rdat;
  reg bus_valid, bus_dma, bus_fetch, bus_write, bus_dual, rerr;
  reg bus_branch_first, cpu_defer;
  reg [1:0] bus_size;
  reg [3:0] mask_lvl;
  wire pready, pslverr, break_ack, break_req_r, break_on_fetch_r, ae_r;
  wire break_after_addr_err_r;
  wire [31:0] prdata, break_pc_r, pc_r;
  wire [7:0] taken_r;
  integer error_cnt, n_checks, i;

  bcu_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .bus_valid(bus_valid),
    .bus_addr(bus_addr), .bus_dma(bus_dma), .bus_fetch(bus_fetch),
    .bus_write(bus_write), .bus_size(bus_size), .bus_dual(bus_dual),
    .bus_branch_first(bus_branch_first), .cpu_defer(cpu_defer),
    .cpu_next_pc(cpu_next_pc), .break_ack(break_ack),
    .break_req_r(break_req_r), .break_pc_r(break_pc_r),
    .break_on_fetch_r(break_on_fetch_r),
    .break_after_addr_err_r(break_after_addr_err_r));
  bcu_irq_model u_irq (.clk(clk), .rst(rst), .break_req_r(break_req_r),
    .break_pc_r(break_pc_r), .break_after_addr_err_r(break_after_addr_err_r),
    .mask_lvl(mask_lvl), .break_ack(break_ack), .taken_r(taken_r),
    .pc_r(pc_r), .ae_r(ae_r));

  // 10 MHz clock
  always #50 clk = ~clk;

  // Print counts and verdict, then stop
  task tally_and_finish;
    begin
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // One APB transfer, answer awaited under a bound
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (pready !== 1'b1 && k < 16);
      if (k == 16) begin
        error_cnt = error_cnt + 1;
        tally_and_finish;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // One monitored bus cycle; f = br, dma, fetch, write, size, dual, defer
  task bcy(input [7:0] f, input [31:0] a);
    begin
      @(posedge clk);
      {bus_branch_first, bus_dma, bus_fetch, bus_write, bus_size, bus_dual,
        cpu_defer} <= f;
      bus_addr <= a;
      bus_valid <= 1'b1;
      @(posedge clk);
      // Attributes no longer hold the last value once released
      {bus_branch_first, bus_dma, bus_fetch, bus_write, bus_size, bus_dual,
        cpu_defer} <= ~f;
      bus_addr <= ~a;
      bus_valid <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask

  // Program a condition, run one cycle, expect n breaks and last pc
  task bk(input [7:0] s, input [31:0] a, input [31:0] m, input [7:0] f,
    input [31:0] ba, input [7:0] n, input [31:0] pc);
    reg [7:0] t0;
    begin
      apb(1'b1, 8'h00, {16'h0, a[31:16]});
      apb(1'b1, 8'h04, {16'h0, a[15:0]});
      apb(1'b1, 8'h08, {16'h0, m[31:16]});
      apb(1'b1, 8'h0c, {16'h0, m[15:0]});
      apb(1'b1, 8'h10, {24'h0, s});
      t0 = taken_r;
      bcy(f, ba);
      `CHK("breaks", n, taken_r - t0)
      if (n != 8'h00)
        `CHK("pc", pc, pc_r)
    end
  endtask

  initial begin
    {clk, psel, penable, pwrite, bus_valid, bus_dma, bus_fetch} = 7'h0;
    {bus_write, bus_dual, bus_branch_first, cpu_defer, rerr} = 5'h0;
    {paddr, pwdata, bus_addr, rdat, bus_size} = 106'h0;
    cpu_next_pc = 32'habc;
    mask_lvl = 4'h0;
    error_cnt = 0;
    n_checks = 0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values, reserved bits, unmapped place
    for (i = 0; i < 7; i = i + 1) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      `CHK("rst", 32'h0, rdat)
      `CHK("err", i == 6, rerr)
      apb(1'b1, 8'(i * 4), 32'hffffffff);
      apb(1'b0, 8'(i * 4), 32'h0);
      `CHK("rw", i < 4 ? 32'hffff : i == 4 ? 32'hff : i == 5 ? 32'h1
        : 32'h0, rdat)
    end
    apb(1'b1, 8'h14, 32'h0);
    bk(8'h54, 32'h404, 0, 8'h28, 32'h404, 1, 32'h404);
    bk(8'h58, 32'h15389c, 0, 8'h28, 32'h15389c, 0, 0);
    bk(8'h54, 32'h30147, 0, 8'h28, 32'h30146, 0, 0);
    bk(8'h6a, 32'h123456, 0, 8'h18, 32'h123456, 1, 32'habc);
    bk(8'h6a, 32'h123456, 0, 8'h14, 32'h123456, 0, 0);
    bk(8'h66, 32'ha80391, 0, 8'h08, 32'ha80390, 0, 0);
    bk(8'ha7, 32'h76bcdc, 0, 8'h4c, 32'h76bcdc, 1, 32'habc);
    bk(8'h94, 32'h2345c8, 0, 8'h68, 32'h2345c8, 0, 0);
    bk(8'he9, 32'h500, 0, 8'h54, 32'h500, 1, 32'habc);
    bk(8'h6e, 32'h600, 0, 8'h08, 32'h600, 1, 32'habc);
    // Initiator, kind and direction fields zero in turn
    for (i = 0; i < 3; i = i + 1)
      bk(8'h54 & ~(8'hc0 >> (2 * i)), 32'h404, 0, 8'h28,
        32'h404, 0, 0);
    bk(8'h54, 32'h400, 32'hf, 8'h28, 32'h40a, 1, 32'h40a);
    bk(8'h54, 32'h404, 0, 8'h29, 32'h404, 1, 32'h406);
    bk(8'h54, 32'h406, 0, 8'h2a, 32'h404, 1, 32'h406);
    bk(8'h54, 32'h404, 32'h2, 8'h2a, 32'h404, 2, 32'h406);
    bk(8'h54, 32'h30147, 0, 8'ha8, 32'h30147, 1, 32'h30147);
    `CHK("odd", 1'b1, ae_r)
    apb(1'b1, 8'h14, 32'h1);
    bk(8'h54, 32'h404, 0, 8'h28, 32'h404, 0, 0);
    apb(1'b1, 8'h14, 32'h0);
    // Held pending at mask 15, taken once lowered
    mask_lvl <= 4'hf;
    bk(8'h54, 32'h408, 0, 8'h28, 32'h408, 0, 0);
    `CHK("pend", 1'b1, break_req_r)
    `CHK("req pc", 32'h408, break_pc_r)
    `CHK("fetch", 1'b1, break_on_fetch_r)
    mask_lvl <= 4'he;
    repeat (3) @(posedge clk);
    `CHK("late pc", 32'h408, pc_r)
    tally_and_finish;
  end
endmodule // tb_top
